// ---- rtl/wdss_pkg.sv ----
package wdss_pkg;

  // Clock rate of mclk
  localparam int unsigned CLK_MHZ        = 25;

  // Recovery and reset-release times, in microseconds
  localparam int unsigned REC_TIME_US    = 1000;
  localparam int unsigned RPU_TIME_US    = 100000;

  // Register offsets on the four-bit register address
  localparam logic [3:0] OFF_FLAGS       = 4'h0;
  localparam logic [3:0] OFF_INTR        = 4'h6;
  localparam logic [3:0] OFF_WDOG        = 4'h7;
  localparam logic [3:0] OFF_SECONDS     = 4'h9;
  localparam logic [3:0] OFF_DAY         = 4'hB;

  // Field positions
  localparam int unsigned FLAGS_WF_BIT   = 7;
  localparam int unsigned INTR_AE_BIT    = 7;
  localparam int unsigned INTR_ABE_BIT   = 5;
  localparam int unsigned WDOG_STEER_BIT = 7;
  localparam int unsigned WDOG_MULT_LSB  = 2;
  localparam int unsigned WDOG_MULT_W    = 5;
  localparam int unsigned WDOG_RES_W     = 2;
  localparam int unsigned SEC_OSC_BIT    = 7;
  localparam int unsigned DAY_FT_BIT     = 6;

  // Reset values
  localparam logic [7:0] WDOG_RESET      = 8'h00;
  localparam logic [7:0] INTR_RESET      = 8'h00;
  localparam logic       OSC_STOP_RESET  = 1'b1;

  // Oscillator divider: 2048 edges per sixteenth second
  localparam int unsigned DIV_W          = 11;
  // Square wave toggles every 32 edges, giving 512 Hz
  localparam int unsigned SQ_BITS        = 5;
  localparam logic [SQ_BITS-1:0] SQ_LAST = 5'h1F;

  // Width of the sixteenth-second tick counter (31 x 64 max)
  localparam int unsigned WCNT_W         = 11;
  localparam int unsigned PCNT_W         = 24;

  // Asynchronous pins of the device
  typedef struct packed {
    logic       cs_b;
    logic       ce_b;
    logic       oe_b;
    logic       we_b;
    logic [3:0] addr;
    logic [7:0] dq;
    logic       osc;
    logic       supply_ok;
  } wdss_pins_t;

  // Supply sequencing states
  typedef enum logic [1:0] {
    PW_OFF,
    PW_RAMP,
    PW_RUN
  } wdss_pwr_t;

  // Synchroniser state
  typedef struct packed {
    wdss_pins_t s1;
    wdss_pins_t s2;
  } wdss_sync_t;

  // Whole state of the top module
  typedef struct packed {
    wdss_pwr_t           pwr;
    logic [PCNT_W-1:0]   pcnt;
    logic                acc_en;
    logic                rst_drv;
    logic                rd_prev;
    logic                wr_prev;
    logic [3:0]          adr_prev;
    logic [7:0]          dat_prev;
    logic                osc_prev;
    logic [DIV_W-1:0]    div;
    logic                sq;
    logic [7:0]          wdog;
    logic [7:0]          intr;
    logic                osc_stop;
    logic                ft;
    logic                wf;
    logic [WCNT_W-1:0]   wcnt;
    logic                irq_drv;
    logic                pin_lo;
    logic [7:0]          dq_o;
    logic                dq_oe;
  } wdss_state_t;

endpackage

// ---- rtl/wdss_sync.sv ----
`timescale 1ns/1ns
module wdss_sync (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire wdss_pkg::wdss_pins_t pins_i,
  output wdss_pkg::wdss_pins_t   pins_o
);

  wdss_pkg::wdss_sync_t s_q;   // Two stages of flops
  wdss_pkg::wdss_sync_t s_d;   // Next value

  // Second stage only reads the first; nothing else does
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pins_i;
    s_d.s2 = s_q.s1;
  end

  // Idle pins are high except osc, which is low; supply counts as absent in reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q         <= '1;
      s_q.s1.supply_ok <= 1'b0;
      s_q.s2.supply_ok <= 1'b0;
      s_q.s1.osc  <= 1'b0;
      s_q.s2.osc  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o = s_q.s2;

endmodule

// ---- rtl/wdss_top.sv ----
// Behaviour
// - Five multiplier bits above two resolution bits
// - Resolution 1/16, 1/4, 1, 4 seconds
// - Timeout equals multiplier times resolution
// - Expiry sets timeout flag, raises interrupt
// - Interrupt holds until flags read or watchdog access
// - Steering bit zero routes expiry to pin
// - Any watchdog access restarts the count
// - Writing zero disables the watchdog
// - Power-up clears watchdog register to zero
// - Power application clears steering, timeout, alarm enables
// - Low supply blocks writes, inputs, data outputs
// - Access allowed after recovery time above trip
// - Reset output asserted while supply below trip
// - Reset released after trip plus release delay
// - Frequency test gives 512 Hz square wave
`timescale 1ns/1ns
module wdss_top #(
  parameter int unsigned REC_CYCLES =
    wdss_pkg::REC_TIME_US * wdss_pkg::CLK_MHZ,
  parameter int unsigned RPU_CYCLES =
    wdss_pkg::RPU_TIME_US * wdss_pkg::CLK_MHZ
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       cs_b,
  input  wire logic       ce_b,
  input  wire logic       oe_b,
  input  wire logic       we_b,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] dq_i,
  output logic      [7:0] dq_o,
  output logic            dq_oe,
  input  wire logic       osc_32k,
  input  wire logic       supply_ok,
  input  wire logic       irq_freq_test_in,
  output logic            irq_freq_test_out,
  output logic            irq_freq_test_oe,
  input  wire logic       rst_out_in,
  output logic            rst_out_b,
  output logic            rst_out_oe
);

  wdss_pkg::wdss_pins_t  raw;     // Pins as they arrive
  wdss_pkg::wdss_pins_t  pin;     // Pins after two flops
  wdss_pkg::wdss_state_t s_q;     // Registered state
  wdss_pkg::wdss_state_t s_d;     // Next state
  localparam int unsigned PCNT_W = wdss_pkg::PCNT_W; // Supply counter width

  // Pin readbacks are not needed by this logic
  logic unused_readback;
  assign unused_readback = irq_freq_test_in ^ rst_out_in;

  // Gather asynchronous pins into one carrier
  always_comb begin
    raw.cs_b      = cs_b;
    raw.ce_b      = ce_b;
    raw.oe_b      = oe_b;
    raw.we_b      = we_b;
    raw.addr      = addr;
    raw.dq        = dq_i;
    raw.osc       = osc_32k;
    raw.supply_ok = supply_ok;
  end

  // Every pin crosses two flops before it is used
  wdss_sync u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pins_i (raw),
    .pins_o (pin)
  );

  // Timeout in sixteenth-second ticks
  function automatic logic [wdss_pkg::WCNT_W-1:0] wd_limit(
    input logic [7:0] w
  );
    logic [wdss_pkg::WCNT_W-1:0] m;
    logic [wdss_pkg::WDOG_RES_W-1:0] r;
    m = '0;
    r = w[wdss_pkg::WDOG_RES_W-1:0];
    m[wdss_pkg::WDOG_MULT_W-1:0] =
      w[wdss_pkg::WDOG_MULT_LSB +: wdss_pkg::WDOG_MULT_W];
    // resolution scaling
    // Each resolution step is four times the last: shift by 2r
    // multiply by shift
    wd_limit = m << {r, 1'b0};
  endfunction

  // Register read mux
  function automatic logic [7:0] rd_mux(
    input logic [3:0]            a,
    input wdss_pkg::wdss_state_t s
  );
    rd_mux = 8'h00;
    case (a)
      wdss_pkg::OFF_FLAGS: begin
        rd_mux[wdss_pkg::FLAGS_WF_BIT] = s.wf;
      end
      wdss_pkg::OFF_INTR: begin
        rd_mux = s.intr;
      end
      wdss_pkg::OFF_WDOG: begin
        rd_mux = s.wdog;
      end
      wdss_pkg::OFF_SECONDS: begin
        rd_mux[wdss_pkg::SEC_OSC_BIT] = s.osc_stop;
      end
      wdss_pkg::OFF_DAY: begin
        rd_mux[wdss_pkg::DAY_FT_BIT] = s.ft;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic                        rd_now;
    logic                        wr_now;
    logic                        rd_end;
    logic                        wr_end;
    logic                        wd_touch;
    logic                        wf_clr;
    logic                        wf_set;
    logic                        osc_edge;
    logic                        tick;
    logic [wdss_pkg::WCNT_W-1:0] lim;
    logic                        ft_mode;
    logic                        pwr_apply;
    logic                        acc_ok;
    rd_now    = 1'b0;
    wr_now    = 1'b0;
    rd_end    = 1'b0;
    wr_end    = 1'b0;
    wd_touch  = 1'b0;
    wf_clr    = 1'b0;
    wf_set    = 1'b0;
    osc_edge  = 1'b0;
    tick      = 1'b0;
    lim       = '0;
    ft_mode   = 1'b0;
    pwr_apply = 1'b0;
    acc_ok    = 1'b0;
    s_d       = s_q;
    s_d.pin_lo = 1'b0;

    // Supply sequencing: recovery gate and reset release
    case (s_q.pwr)
      wdss_pkg::PW_OFF: begin
        s_d.acc_en  = 1'b0;
        s_d.rst_drv = 1'b1;
        if (pin.supply_ok) begin
          s_d.pwr   = wdss_pkg::PW_RAMP;
          s_d.pcnt  = '0;
          pwr_apply = 1'b1;
        end
      end
      wdss_pkg::PW_RAMP: begin
        if (!pin.supply_ok) begin
          // Supply dipped again: start the wait over
          s_d.pwr    = wdss_pkg::PW_OFF;
          s_d.acc_en = 1'b0;
        end else begin
          s_d.pcnt = s_q.pcnt + 1'b1;
          if (s_q.pcnt == PCNT_W'(REC_CYCLES - 1)) begin
            s_d.acc_en = 1'b1;
          end
          if (s_q.pcnt == PCNT_W'(RPU_CYCLES - 1)) begin
            s_d.pwr     = wdss_pkg::PW_RUN;
            s_d.rst_drv = 1'b0;
          end
        end
      end
      wdss_pkg::PW_RUN: begin
        if (!pin.supply_ok) begin
          s_d.pwr     = wdss_pkg::PW_OFF;
          s_d.acc_en  = 1'b0;
          s_d.rst_drv = 1'b1;
        end
      end
      default: begin
        s_d.pwr = wdss_pkg::PW_OFF;
      end
    endcase

    // Supply loss at the pin closes the port in the same cycle
    acc_ok = s_q.acc_en && pin.supply_ok;
    // Bus cycle decode; overlapping selects are not decoded
    // memory select gates clock port
    if (acc_ok && !pin.cs_b && pin.ce_b) begin
      rd_now = pin.we_b && !pin.oe_b;
      wr_now = !pin.we_b;
    end
    // Effects land at cycle end; a cycle cut by supply loss drops
    rd_end = s_q.rd_prev && !rd_now && acc_ok;
    wr_end = s_q.wr_prev && !wr_now && acc_ok;
    s_d.rd_prev = rd_now;
    s_d.wr_prev = wr_now;
    if (rd_now || wr_now) begin
      s_d.adr_prev = pin.addr;
      s_d.dat_prev = pin.dq;
    end

    // Data outputs, released whenever access is closed
    // outputs floated
    s_d.dq_oe = rd_now;
    s_d.dq_o  = rd_now ? rd_mux(pin.addr, s_q) : 8'h00;

    // Register writes
    if (wr_end) begin
      case (s_q.adr_prev)
        wdss_pkg::OFF_INTR: begin
          s_d.intr = s_q.dat_prev;
        end
        wdss_pkg::OFF_WDOG: begin
          s_d.wdog = s_q.dat_prev;
        end
        wdss_pkg::OFF_SECONDS: begin
          s_d.osc_stop = s_q.dat_prev[wdss_pkg::SEC_OSC_BIT];
        end
        wdss_pkg::OFF_DAY: begin
          s_d.ft = s_q.dat_prev[wdss_pkg::DAY_FT_BIT];
        end
        default: begin
          s_d.ft = s_q.ft;
        end
      endcase
    end

    wd_touch = (rd_end || wr_end) && (s_q.adr_prev == wdss_pkg::OFF_WDOG);
    // clear on flags read or watchdog access
    wf_clr = wd_touch ||
      (rd_end && (s_q.adr_prev == wdss_pkg::OFF_FLAGS));

    // Oscillator edges; a stopped oscillator gives none
    // count oscillator edges
    s_d.osc_prev = pin.osc;
    osc_edge = pin.osc && !s_q.osc_prev && !s_q.osc_stop;
    if (osc_edge) begin
      s_d.div = s_q.div + 1'b1;
      tick    = (s_q.div == '1);
      if (s_q.div[wdss_pkg::SQ_BITS-1:0] == wdss_pkg::SQ_LAST) begin
        s_d.sq = !s_q.sq;
      end
    end

    // Watchdog counter
    lim = wd_limit(s_q.wdog);
    if (wd_touch) begin
      // Restart also zeroes the divider so the first period is
      // whole; the square wave phase jumps as the price
      s_d.wcnt = '0;
      s_d.div  = '0;
    end else if (tick && (s_q.wdog != wdss_pkg::WDOG_RESET) &&
                 (lim != '0)) begin
      if (s_q.wcnt == lim - 1'b1) begin
        wf_set   = 1'b1;
        s_d.wcnt = '0;
      end else begin
        s_d.wcnt = s_q.wcnt + 1'b1;
      end
    end

    // A set in the same cycle as a clear wins
    if (wf_set) begin
      s_d.wf = 1'b1;
    end else if (wf_clr) begin
      s_d.wf = 1'b0;
    end

    // Each power application clears the control bits
    if (pwr_apply) begin
      s_d.wdog = wdss_pkg::WDOG_RESET;
      s_d.intr[wdss_pkg::INTR_AE_BIT]  = 1'b0;
      s_d.intr[wdss_pkg::INTR_ABE_BIT] = 1'b0;
      s_d.ft   = 1'b0;
      s_d.wcnt = '0;
    end

    // Pin drive: frequency test overrides the watchdog
    // test mode condition
    ft_mode = s_q.ft && !s_q.intr[wdss_pkg::INTR_AE_BIT] &&
      (s_q.wdog[wdss_pkg::WDOG_STEER_BIT] ||
       (s_q.wdog == wdss_pkg::WDOG_RESET));
    if (!acc_ok) begin
      s_d.irq_drv = 1'b0;
    end else if (ft_mode) begin
      s_d.irq_drv = !s_q.sq;
    end else begin
      s_d.irq_drv = s_q.wf && !s_q.wdog[wdss_pkg::WDOG_STEER_BIT];
    end
  end

  // Single register bank
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.rst_drv  <= 1'b1;
      s_q.osc_stop <= wdss_pkg::OSC_STOP_RESET;
      s_q.wdog     <= wdss_pkg::WDOG_RESET;
      s_q.intr     <= wdss_pkg::INTR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Open-drain pins only ever drive low
  // open drain outputs
  assign irq_freq_test_out = s_q.pin_lo;
  assign irq_freq_test_oe  = s_q.irq_drv;
  assign rst_out_b         = s_q.pin_lo;
  assign rst_out_oe        = s_q.rst_drv;
  assign dq_o              = s_q.dq_o;
  assign dq_oe             = s_q.dq_oe;

endmodule

// ---- tb/wdss_asserts.sv ----
`timescale 1ns/1ns
// Port-level checks of the supervisor top
module wdss_asserts #(
  parameter int unsigned REC_CYCLES = 20,
  parameter int unsigned RPU_CYCLES = 50
) (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       ce_b,
  input wire logic       oe_b,
  input wire logic       we_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] dq_i,
  input wire logic [7:0] dq_o,
  input wire logic       dq_oe,
  input wire logic       osc_32k,
  input wire logic       supply_ok,
  input wire logic       irq_freq_test_in,
  input wire logic       irq_freq_test_out,
  input wire logic       irq_freq_test_oe,
  input wire logic       rst_out_in,
  input wire logic       rst_out_b,
  input wire logic       rst_out_oe
);
  // Cycles of supply high at the pin; it leads the synced copy
  int unsigned hi_cnt_q;

  // Saturating counter, margin covers synchroniser delay
  always_ff @(posedge mclk) begin
    if (!rst_b || !supply_ok) begin
      hi_cnt_q <= 0;
    end else if (hi_cnt_q < RPU_CYCLES + 8) begin
      hi_cnt_q <= hi_cnt_q + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_irq_od_data: assert property (irq_freq_test_out == 1'b0)
    else $error("interrupt pin data not low");
  a_rst_od_data: assert property (rst_out_b == 1'b0)
    else $error("reset pin data not low");
  a_rst_on_drop: assert property (!supply_ok [*4] |-> rst_out_oe)
    else $error("reset output not asserted on low supply");
  a_quiet_on_drop: assert property (
    !supply_ok [*4] |-> !dq_oe && !irq_freq_test_oe)
    else $error("outputs driven on low supply");
  a_rst_hold_long: assert property (
    $fell(rst_out_oe) |-> hi_cnt_q >= RPU_CYCLES)
    else $error("reset output released too early");
  a_rst_release_due: assert property (
    hi_cnt_q == RPU_CYCLES + 8 |-> !rst_out_oe)
    else $error("reset output held too long");
  a_read_needs_sel: assert property (
    $rose(dq_oe) |-> !$past(cs_b, 3) && !$past(oe_b, 3) &&
      $past(ce_b, 3) && $past(we_b, 3))
    else $error("data driven without a clean read cycle");
  a_open_after_rec: assert property (
    dq_oe |-> hi_cnt_q >= REC_CYCLES)
    else $error("read answered before recovery");

  c_expiry: cover property ($rose(irq_freq_test_oe));
  c_release: cover property ($fell(rst_out_oe));
  c_read: cover property ($rose(dq_oe));
endmodule

bind wdss_top wdss_asserts #(
  .REC_CYCLES(REC_CYCLES),
  .RPU_CYCLES(RPU_CYCLES)
) u_chk (
  .mclk, .rst_b, .cs_b, .ce_b, .oe_b, .we_b, .addr, .dq_i, .dq_o,
  .dq_oe, .osc_32k, .supply_ok, .irq_freq_test_in, .irq_freq_test_out,
  .irq_freq_test_oe, .rst_out_in, .rst_out_b, .rst_out_oe
);

// ---- tb/wdss_host.sv ----
`timescale 1ns/1ns
// Host processor on the asynchronous register pins
module wdss_host (
  input  wire logic       mclk,
  input  wire logic [7:0] dq_o,
  input  wire logic       dq_oe,
  output logic            cs_b,
  output logic            ce_b,
  output logic            oe_b,
  output logic            we_b,
  output logic [3:0]      addr,
  output logic [7:0]      dq_i
);
  // Write phase length; raise it for a slow host
  int unsigned ph = 4;

  initial begin
    cs_b = 1'b1;
    ce_b = 1'b1;
    oe_b = 1'b1;
    we_b = 1'b1;
    addr = 4'h0;
    dq_i = 8'hA5;
  end

  // Write cycle; data kept past the end, then bus shows inverse
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    dq_i <= (a == 4'h7) ? (d & 8'h7F) : d;
    cs_b <= 1'b0;
    we_b <= 1'b0;
    repeat (ph) @(posedge mclk);
    cs_b <= 1'b1;
    we_b <= 1'b1;
    repeat (4) @(posedge mclk);
    dq_i <= ~d;
    repeat (2) @(posedge mclk);
  endtask

  // Read cycle held until data is driven, bounded wait
  task automatic rd(input logic [3:0] a, output logic [7:0] d,
                    output bit g);
    int n;
    g = 1'b0;
    d = 8'h00;
    @(posedge mclk);
    addr <= a;
    cs_b <= 1'b0;
    oe_b <= 1'b0;
    for (n = 0; n < 12 && !g; n++) begin
      @(posedge mclk);
      if (dq_oe === 1'b1) begin
        g = 1'b1;
        d = dq_o;
      end
    end
    cs_b <= 1'b1;
    oe_b <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
endmodule

// ---- tb/wdss_tb.sv ----
`timescale 1ns/1ns
module wdss_tb;
  // Short supply counts keep the run brief
  localparam int unsigned REC  = 40;
  localparam int unsigned RPU  = 100;
  // Oscillator edges per sixteenth tick
  localparam int unsigned TICK = 2048;

  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        supply_ok = 1'b0;
  logic        osc_32k = 1'b0;
  logic        cs_b, ce_b, oe_b, we_b, dq_oe;
  logic [3:0]  addr;
  logic [7:0]  dq_i, dq_o;
  logic        irq_freq_test_out, irq_freq_test_oe;
  logic        rst_out_b, rst_out_oe, last;
  int          bad_count, samples_checked, cyc, tog;
  logic [31:0] rng = 32'h3A271BC1;
  logic [7:0]  m_q[$];
  logic [7:0]  wd_tab[5] = '{8'h04, 8'h08, 8'h05, 8'h06, 8'h07};

  always #20 mclk = ~mclk;
  // Oscillator sped up to 4 mclk so ticks fit the run
  always #80 osc_32k = ~osc_32k;

  wdss_top #(.REC_CYCLES(REC), .RPU_CYCLES(RPU)) u_dut (
    .mclk, .rst_b, .cs_b, .ce_b, .oe_b, .we_b, .addr, .dq_i, .dq_o,
    .dq_oe, .osc_32k, .supply_ok, .irq_freq_test_out, .irq_freq_test_oe,
    // Pulled-up open-drain pins read back
    .irq_freq_test_in(irq_freq_test_oe ? irq_freq_test_out : 1'b1),
    .rst_out_in(rst_out_oe ? rst_out_b : 1'b1),
    .rst_out_b, .rst_out_oe
  );

  wdss_host u_host (.mclk, .dq_o, .dq_oe, .cs_b, .ce_b, .oe_b, .we_b,
                    .addr, .dq_i);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Model: oscillator edges until expiry
  function automatic int unsigned to_edges(input logic [7:0] w);
    return (TICK * w[6:2]) << (2 * w[1:0]);
  endfunction

  task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_pin(string nm, logic e, logic s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic rdc(logic [3:0] a, logic ok, logic [7:0] e);
    logic [7:0] d;
    bit         g;
    u_host.rd(a, d, g);
    chk_pin("read answered", ok, g);
    if (ok) begin
      chk_reg("read data", e, d);
    end
  endtask

  // Short timeouts run to expiry, long ones must stay quiet
  task automatic run_wd(logic [7:0] w);
    int unsigned n;
    n = to_edges(w);
    u_host.wr(4'h7, w);
    if (n <= 2 * TICK) begin
      repeat (n - 64) @(posedge osc_32k);
      chk_pin("irq early", 1'b0, irq_freq_test_oe);
      repeat (128) @(posedge osc_32k);
      chk_pin("irq on expiry", 1'b1, irq_freq_test_oe);
      rdc(4'h0, 1'b1, 8'h80);
      chk_pin("irq after flags", 1'b0, irq_freq_test_oe);
    end else begin
      repeat (TICK + 64) @(posedge osc_32k);
      chk_pin("irq long", 1'b0, irq_freq_test_oe);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chk_pin("reset low supply", 1'b1, rst_out_oe);
    supply_ok <= 1'b1;
    repeat (RPU / 2) @(posedge mclk);
    chk_pin("reset held", 1'b1, rst_out_oe);
    repeat (RPU) @(posedge mclk);
    chk_pin("reset released", 1'b0, rst_out_oe);
    rdc(4'h7, 1'b1, 8'h00);
    rdc(4'h6, 1'b1, 8'h00);
    repeat (4) begin
      rng = xs(rng);
      m_q.push_back(rng[7:0]);
      u_host.wr(4'h6, rng[7:0]);
      rdc(4'h6, 1'b1, m_q.pop_front());
    end
    u_host.wr(4'h6, 8'h00);
    u_host.wr(4'h9, 8'h00);
    foreach (wd_tab[i]) run_wd(wd_tab[i]);
    u_host.wr(4'h7, 8'h04);
    repeat (TICK - 500) @(posedge osc_32k);
    rdc(4'h7, 1'b1, 8'h04);
    repeat (TICK - 500) @(posedge osc_32k);
    chk_pin("irq restarted", 1'b0, irq_freq_test_oe);
    repeat (600) @(posedge osc_32k);
    chk_pin("irq full period", 1'b1, irq_freq_test_oe);
    u_host.wr(4'h7, 8'h00);
    chk_pin("irq on write", 1'b0, irq_freq_test_oe);
    repeat (TICK + 64) @(posedge osc_32k);
    chk_pin("irq disabled", 1'b0, irq_freq_test_oe);
    u_host.wr(4'hB, 8'h40);
    last = irq_freq_test_oe;
    repeat (1280) begin
      @(posedge mclk);
      tog += (irq_freq_test_oe !== last);
      last = irq_freq_test_oe;
    end
    chk_pin("square rate", 1'b1, tog >= 9 && tog <= 11);
    u_host.wr(4'hB, 8'h00);
    u_host.wr(4'h6, 8'hA0);
    u_host.wr(4'h7, 8'h04);
    supply_ok <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_pin("reset on drop", 1'b1, rst_out_oe);
    rdc(4'h7, 1'b0, 8'h00);
    supply_ok <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(4'h7, 1'b0, 8'h00);
    repeat (RPU + 10) @(posedge mclk);
    chk_pin("reset after return", 1'b0, rst_out_oe);
    chk_pin("od data", 1'b0, irq_freq_test_out | rst_out_b);
    rdc(4'h7, 1'b1, 8'h00);
    rdc(4'h6, 1'b1, 8'h00);
    end_of_test();
  end
endmodule
